//--- design/ccbda_alu.v
// Clear, compare, BCD add, decrement and call-target datapath on APB
`timescale 1ns/1ps
`include "ccbda_defines.vh"
module ccbda_alu #(
	parameter AW = 8,
	parameter XW = 20
) (
	input wire clock,
	input wire rst_b,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [AW-1:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output reg pslverr,
	output reg [XW-1:0] result_out,
	output reg result_we,
	output reg [15:0] status_out
);
	// Software-visible operands and call registers
	reg [3:0] op;
	reg byte_mode;
	reg go;
	reg [XW-1:0] src;
	reg [XW-1:0] dst;
	reg [15:0] memw;
	reg [15:0] offs;
	reg [XW-1:0] faddr;
	reg [XW-1:0] target;
	reg wrote;
	reg bad_op;

	// Combinational work, recomputed every cycle
	reg [XW-1:0] next_res;
	reg [15:0] next_status;
	reg next_we;
	reg next_bad;
	reg [XW-1:0] next_faddr;
	reg [XW-1:0] next_tgt;
	reg [15:0] res16;
	reg arith;
	reg ar_c;
	reg ar_v;
	reg ar_n;
	reg ar_z;
	reg [31:0] next_rdata;
	reg next_err;

	wire setup = psel & ~penable;
	wire apb_wr = psel & penable & pwrite;
	wire [7:0] addr8 = paddr[7:0];
	wire addr_hi;
	wire reg_wr;
	wire [XW-1:0] fetched;

	// Slave never inserts wait states
	assign pready = 1'b1;

	// Wider buses must not alias the eight-bit map
	generate
		if (AW > 8) begin : g_addr_hi
			assign addr_hi = |paddr[AW-1:8];
		end else begin : g_addr_fit
			assign addr_hi = 1'b0;
		end
	endgenerate

	// A write refused at setup never lands
	assign reg_wr = apb_wr & ~pslverr;

	// Call targets live in the lower 64KB
	assign fetched = {{(XW-16){1'b0}}, memw};

	// Subtrahend shared by compare and both decrements
	wire [15:0] sub_k = (op == `CCBDA_OP_SUB1) ? `CCBDA_CONST_ONE :
		(op == `CCBDA_OP_SUB2) ? `CCBDA_CONST_TWO : src[15:0];
	wire [16:0] diff_w = {1'b0, dst[15:0]} + {1'b0, ~sub_k} +
		17'h00001;
	wire [8:0] diff_b = {1'b0, dst[7:0]} + {1'b0, ~sub_k[7:0]} +
		9'h001;

	// Add-carry is add with a zero source
	wire [15:0] bcd_src = (op == `CCBDA_OP_BCD_ADD_CARRY) ? 16'h0000 :
		src[15:0];
	wire [15:0] bcd_sum;
	wire [3:0] bcd_cy;

	ccbda_bcd_add #(
		.DIGITS(4)
	) u_bcd (
		.a(dst[15:0]),
		.b(bcd_src),
		.cin(status_out[`CCBDA_STAT_C]),
		.sum(bcd_sum),
		.carry(bcd_cy)
	);

	always @* begin
		next_res = dst;
		next_status = status_out;
		next_we = 1'b0;
		next_bad = 1'b0;
		next_faddr = faddr;
		next_tgt = target;
		res16 = 16'h0000;
		arith = 1'b0;
		ar_c = 1'b0;
		ar_v = 1'b0;
		ar_n = 1'b0;
		ar_z = 1'b0;

		case (op)
		`CCBDA_OP_CLEAR_DEST: begin
			next_res = {XW{1'b0}};
			next_we = 1'b1;
		end
		`CCBDA_OP_CARRY_CLEAR: begin
			next_status = status_out & `CCBDA_MASK_C_INV;
		end
		`CCBDA_OP_NEG_CLEAR: begin
			next_status = status_out & `CCBDA_MASK_N_INV;
		end
		`CCBDA_OP_ZERO_CLEAR: begin
			next_status = status_out & `CCBDA_MASK_Z_INV;
		end
		`CCBDA_OP_COMPARE, `CCBDA_OP_SUB1, `CCBDA_OP_SUB2: begin
			arith = 1'b1;
			if (byte_mode) begin
				res16 = {8'h00, diff_b[7:0]};
				ar_c = diff_b[8];
				// Operands of unlike sign, result sign flips
				ar_v = (dst[7] ^ sub_k[7]) &
					(diff_b[7] ^ dst[7]);
			end else begin
				res16 = diff_w[15:0];
				ar_c = diff_w[16];
				ar_v = (dst[15] ^ sub_k[15]) &
					(diff_w[15] ^ dst[15]);
			end
			if (op != `CCBDA_OP_COMPARE) begin
				// Register write-back clears bits above the size
				next_res = {{(XW-16){1'b0}}, res16};
				next_we = 1'b1;
			end
			// Compare leaves the destination whole
		end
		`CCBDA_OP_BCD_ADD_CARRY, `CCBDA_OP_BCD_ADD: begin
			arith = 1'b1;
			// Byte form carries out of the second digit
			if (byte_mode) begin
				res16 = {8'h00, bcd_sum[7:0]};
				ar_c = bcd_cy[1];
			end else begin
				res16 = bcd_sum;
				ar_c = bcd_cy[3];
			end
			// Overflow is undefined here, so it simply holds
			ar_v = status_out[`CCBDA_STAT_V];
			next_res = {{(XW-16){1'b0}}, res16};
			next_we = 1'b1;
		end
		`CCBDA_OP_CALL_AINC: begin
			next_faddr = dst;
			next_tgt = fetched;
			next_res = dst + `CCBDA_PTR_STEP;
			next_we = 1'b1;
		end
		`CCBDA_OP_CALL_IDX: begin
			// Signed offset reaches either way from the register
			next_faddr = dst + {{(XW-16){offs[15]}}, offs};
			next_tgt = fetched;
		end
		default: begin
			next_bad = 1'b1;
		end
		endcase

		if (arith) begin
			ar_n = byte_mode ? res16[7] : res16[15];
			ar_z = byte_mode ? (res16[7:0] == 8'h00) :
				(res16 == 16'h0000);
			// Only flag bits are rewritten, mode bits pass
			next_status[`CCBDA_STAT_C] = ar_c;
			next_status[`CCBDA_STAT_Z] = ar_z;
			next_status[`CCBDA_STAT_N] = ar_n;
			next_status[`CCBDA_STAT_V] = ar_v;
		end
		// Mode bits are software-owned and pass every op
		next_status = (next_status & ~`CCBDA_STAT_MODE_MASK) |
			(status_out & `CCBDA_STAT_MODE_MASK);
	end

	// Read data and error are captured in the setup cycle
	always @* begin
		next_rdata = 32'h00000000;
		next_err = 1'b0;
		case (addr8)
		`CCBDA_OFF_CTRL: begin
			next_rdata[`CCBDA_CTRL_OP_HI:`CCBDA_CTRL_OP_LO] = op;
			next_rdata[`CCBDA_CTRL_BYTE] = byte_mode;
		end
		`CCBDA_OFF_SRC: begin
			next_rdata[XW-1:0] = src;
		end
		`CCBDA_OFF_DST: begin
			next_rdata[XW-1:0] = dst;
		end
		`CCBDA_OFF_STATUS: begin
			next_rdata[15:0] = status_out;
		end
		`CCBDA_OFF_RES: begin
			next_rdata[XW-1:0] = result_out;
		end
		`CCBDA_OFF_INFO: begin
			next_rdata[`CCBDA_INFO_WROTE] = wrote;
			next_rdata[`CCBDA_INFO_BAD] = bad_op;
			next_rdata[`CCBDA_INFO_OP_LO+3:`CCBDA_INFO_OP_LO] = op;
		end
		`CCBDA_OFF_MEMW: begin
			next_rdata[15:0] = memw;
		end
		`CCBDA_OFF_OFFS: begin
			next_rdata[15:0] = offs;
		end
		`CCBDA_OFF_FADDR: begin
			next_rdata[XW-1:0] = faddr;
		end
		`CCBDA_OFF_TGT: begin
			next_rdata[XW-1:0] = target;
		end
		default: begin
			next_err = 1'b1;
		end
		endcase

		// Unaligned or out-of-map words read zero with an error
		if (paddr[1:0] != 2'b00 || addr_hi) begin
			next_rdata = 32'h00000000;
			next_err = 1'b1;
		end
	end

	always @(posedge clock) begin
		if (!rst_b) begin
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata <= pwrite ? 32'h00000000 : next_rdata;
			pslverr <= next_err;
		end
	end

	// Register writes; an operation launched by go applies next cycle
	always @(posedge clock) begin
		if (!rst_b) begin
			op <= `CCBDA_OP_CLEAR_DEST;
			byte_mode <= 1'b0;
			go <= 1'b0;
			src <= {XW{1'b0}};
			dst <= {XW{1'b0}};
			memw <= 16'h0000;
			offs <= 16'h0000;
			faddr <= {XW{1'b0}};
			target <= {XW{1'b0}};
			result_out <= {XW{1'b0}};
			result_we <= 1'b0;
			status_out <= `CCBDA_STAT_RESET;
			wrote <= 1'b0;
			bad_op <= 1'b0;
		end else begin
			go <= 1'b0;
			result_we <= 1'b0;
			if (go) begin
				status_out <= next_status;
				faddr <= next_faddr;
				target <= next_tgt;
				bad_op <= next_bad;
				wrote <= next_we;
				result_we <= next_we;
				if (next_we) begin
					result_out <= next_res;
					// Destination follows, so ops chain
					dst <= next_res;
				end
			end

			// Next APB access is at least two cycles after go
			// On a clash the software write still wins
			if (reg_wr) begin
				case (addr8)
				`CCBDA_OFF_CTRL: begin
					op <= pwdata[`CCBDA_CTRL_OP_HI:`CCBDA_CTRL_OP_LO];
					byte_mode <= pwdata[`CCBDA_CTRL_BYTE];
					go <= pwdata[`CCBDA_CTRL_GO];
				end
				`CCBDA_OFF_SRC: begin
					src <= pwdata[XW-1:0];
				end
				`CCBDA_OFF_DST: begin
					dst <= pwdata[XW-1:0];
				end
				`CCBDA_OFF_STATUS: begin
					status_out <= pwdata[15:0];
				end
				`CCBDA_OFF_MEMW: begin
					memw <= pwdata[15:0];
				end
				`CCBDA_OFF_OFFS: begin
					offs <= pwdata[15:0];
				end
				default: begin
					op <= op;
				end
				endcase
			end
		end
	end
endmodule

//--- design/ccbda_defines.vh
// Constants of the clear, compare, BCD and decrement datapath
`ifndef CCBDA_DEFINES_VH
`define CCBDA_DEFINES_VH

`define CCBDA_OFF_CTRL 8'h00
`define CCBDA_OFF_SRC 8'h04
`define CCBDA_OFF_DST 8'h08
`define CCBDA_OFF_STATUS 8'h0C
`define CCBDA_OFF_RES 8'h10
`define CCBDA_OFF_INFO 8'h14
`define CCBDA_OFF_MEMW 8'h18
`define CCBDA_OFF_OFFS 8'h1C
`define CCBDA_OFF_FADDR 8'h20
`define CCBDA_OFF_TGT 8'h24

`define CCBDA_CTRL_OP_HI 3
`define CCBDA_CTRL_OP_LO 0
`define CCBDA_CTRL_BYTE 4
`define CCBDA_CTRL_GO 8

`define CCBDA_OP_CLEAR_DEST 4'h0
`define CCBDA_OP_CARRY_CLEAR 4'h1
`define CCBDA_OP_NEG_CLEAR 4'h2
`define CCBDA_OP_ZERO_CLEAR 4'h3
`define CCBDA_OP_COMPARE 4'h4
`define CCBDA_OP_BCD_ADD_CARRY 4'h5
`define CCBDA_OP_BCD_ADD 4'h6
`define CCBDA_OP_SUB1 4'h7
`define CCBDA_OP_SUB2 4'h8
`define CCBDA_OP_CALL_AINC 4'h9
`define CCBDA_OP_CALL_IDX 4'hA

`define CCBDA_STAT_C 0
`define CCBDA_STAT_Z 1
`define CCBDA_STAT_N 2
`define CCBDA_STAT_V 8
`define CCBDA_STAT_INT_ENABLE 3
`define CCBDA_STAT_CORE_HALT 4
`define CCBDA_STAT_OSC_STOP 5
`define CCBDA_STAT_MODE_MASK 16'h0038
`define CCBDA_STAT_RESET 16'h0000
`define CCBDA_MASK_C_INV 16'hFFFE
`define CCBDA_MASK_N_INV 16'hFFFB
`define CCBDA_MASK_Z_INV 16'hFFFD

`define CCBDA_CONST_ONE 16'h0001
`define CCBDA_CONST_TWO 16'h0002
`define CCBDA_PTR_STEP 20'h00002

`define CCBDA_INFO_WROTE 0
`define CCBDA_INFO_BAD 1
`define CCBDA_INFO_OP_LO 4

`endif

//--- design/ccbda_bcd_add.v
// Unsigned BCD adder, one generate stage per decimal digit
`timescale 1ns/1ps
module ccbda_bcd_add #(
	parameter DIGITS = 4
) (
	input wire [4*DIGITS-1:0] a,
	input wire [4*DIGITS-1:0] b,
	input wire cin,
	output wire [4*DIGITS-1:0] sum,
	output wire [DIGITS-1:0] carry
);
	wire [DIGITS:0] chain;

	assign chain[0] = cin;
	assign carry = chain[DIGITS:1];

	genvar i;
	generate
		for (i = 0; i < DIGITS; i = i + 1) begin : g_digit
			wire [4:0] raw;
			wire wrap;
			wire [4:0] fixed;
			assign raw = {1'b0, a[4*i+3:4*i]} + {1'b0, b[4*i+3:4*i]} +
				{4'h0, chain[i]};
			// Non-BCD digits give an undefined but bounded result
			assign wrap = (raw > 5'h09);
			assign fixed = wrap ? raw + 5'h06 : raw;
			assign sum[4*i+3:4*i] = fixed[3:0];
			assign chain[i+1] = wrap;
		end
	endgenerate
endmodule

//--- bench/ccbda_alu_checker.sv
// Port assertions of the clear, compare, BCD and decrement datapath
`timescale 1ns/1ps
module ccbda_alu_checker #(
	parameter AW = 8,
	parameter XW = 20
) (
	input wire clock,
	input wire rst_b,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [AW-1:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire [XW-1:0] result_out,
	input wire result_we,
	input wire [15:0] status_out
);
	// Go write to the control word; outputs follow two edges later
	wire go = psel & penable & pwrite & (paddr == '0) & pwdata[8];
	wire [3:0] op = pwdata[3:0];
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	reset_zero_a:
	assert property (disable iff (1'b0) !rst_b |=> status_out == 16'h0000
		&& !result_we && result_out == '0) else $error("reset values");
	clear_dest_a:
	assert property (go && op == 4'h0 |-> ##2 result_we && result_out == '0
		&& status_out == $past(status_out)) else $error("clear wrong");
	carry_clear_a:
	assert property (go && op == 4'h1 |-> ##2
		status_out == ($past(status_out) & 16'hFFFE))
		else $error("carry clear wrong");
	neg_clear_a:
	assert property (go && op == 4'h2 |-> ##2
		status_out == ($past(status_out) & 16'hFFFB))
		else $error("negative clear wrong");
	zero_clear_a:
	assert property (go && op == 4'h3 |-> ##2
		status_out == ($past(status_out) & 16'hFFFD))
		else $error("zero clear wrong");
	cmp_no_write_a:
	assert property (go && op == 4'h4 |-> ##1 !result_we [*2])
		else $error("compare wrote back");
	mode_bits_a:
	assert property (go |-> ##2 $stable(status_out[5:3]))
		else $error("mode bits changed");
	bad_op_a:
	assert property (go && op > 4'hA |-> ##2 !result_we
		&& status_out == $past(status_out)) else $error("bad op acted");
	apb_ready_a:
	assert property (psel |-> pready) else $error("pready low");
	we_pulse_a:
	assert property (result_we |=> !result_we)
		else $error("write pulse too long");
	sub_write_a:
	assert property (go && (op == 4'h7 || op == 4'h8) |-> ##2 result_we)
		else $error("decrement not written back");
endmodule

//--- bench/clear_compare_bcd_decrement_alu_bench.sv
// Self-checking bench of the clear, compare, BCD and decrement datapath
`timescale 1ns/1ps
`include "ccbda_defines.vh"
module clear_compare_bcd_decrement_alu_bench;
	reg clock = 1'b0;
	reg rst_b = 1'b0;
	reg psel = 1'b0;
	reg penable = 1'b0;
	reg pwrite = 1'b0;
	reg [7:0] paddr = 8'h00;
	reg [31:0] pwdata = 32'h00000000;
	wire [31:0] prdata;
	wire pready;
	wire pslverr;
	wire [19:0] result_out;
	wire result_we;
	wire [15:0] status_out;
	integer mismatches = 0;
	integer n_tests = 0;
	reg [31:0] q;
	reg e;
	always #2 clock = ~clock;
	ccbda_alu i_ccbda_alu (.clock(clock), .rst_b(rst_b), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.result_out(result_out), .result_we(result_we),
		.status_out(status_out));
	task end_sim;
		$display("Checks %0d, mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task chk(input [31:0] ex, input [31:0] got, input string nm);
		n_tests = n_tests + 1;
		if (got !== ex) begin
			mismatches = mismatches + 1;
			$display("[ERR] %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task apb(input [7:0] a, input w, input [31:0] d);
		integer k;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		k = 0;
		@(posedge clock);
		while (pready !== 1'b1 && k < 20) begin
			@(posedge clock);
			k = k + 1;
		end
		if (pready !== 1'b1) begin
			mismatches = mismatches + 1;
			$display("[ERR] pready expected 1 seen %b", pready);
			end_sim;
		end else begin
			q = prdata;
			e = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	// Loads operands, runs one op, reads status and destination back
	task op(input [3:0] c, input b, input [19:0] s, input [19:0] d,
		input [15:0] sr, input [19:0] xd, input [15:0] xs);
		apb(`CCBDA_OFF_SRC, 1'b1, {12'h000, s});
		apb(`CCBDA_OFF_DST, 1'b1, {12'h000, d});
		apb(`CCBDA_OFF_STATUS, 1'b1, {16'h0000, sr});
		apb(`CCBDA_OFF_CTRL, 1'b1, {23'h000000, 1'b1, 3'h0, b, c});
		apb(`CCBDA_OFF_STATUS, 1'b0, 32'h00000000);
		chk({16'h0000, xs}, q, "status");
		apb(`CCBDA_OFF_DST, 1'b0, 32'h00000000);
		chk({12'h000, xd}, q, "destination");
	endtask
	task t_clears;
		op(4'h0, 0, 0, 20'h5ABCD, 16'h013F, 0, 16'h013F);
		chk(32'h00000000, {12'h000, result_out}, "result");
		op(4'h1, 0, 0, 20'h12345, 16'h013F, 20'h12345, 16'h013E);
		op(4'h2, 0, 0, 20'h12345, 16'h013F, 20'h12345, 16'h013B);
		op(4'h3, 0, 0, 20'h12345, 16'h013F, 20'h12345, 16'h013D);
		$display("clears done");
	endtask
	task t_compare;
		op(4'h4, 0, 1, 20'hF8000, 16'h0038, 20'hF8000, 16'h0139);
		op(4'h4, 1, 20'h55, 20'hA5F55, 0, 20'hA5F55, 16'h0003);
		op(4'h4, 0, 2, 1, 0, 1, 16'h0004);
		op(4'h4, 1, 1, 20'h00080, 0, 20'h00080, 16'h0101);
		chk(32'h00000000, {12'h000, result_out}, "result");
		$display("compare done");
	endtask
	task t_bcd;
		op(4'h6, 0, 1, 20'h09999, 0, 0, 16'h0003);
		op(4'h6, 1, 20'h45, 20'hFFF34, 1, 20'h80, 16'h0004);
		op(4'h5, 0, 0, 20'h07999, 1, 20'h08000, 16'h0004);
		op(4'h5, 1, 0, 20'h00099, 1, 0, 16'h0003);
		$display("decimal done");
	endtask
	task t_decs;
		op(4'h7, 0, 0, 20'h08000, 0, 20'h07FFF, 16'h0101);
		op(4'h7, 0, 0, 1, 0, 0, 16'h0003);
		op(4'h7, 1, 0, 0, 0, 20'h000FF, 16'h0004);
		op(4'h7, 1, 0, 20'h00080, 0, 20'h0007F, 16'h0101);
		op(4'h8, 0, 0, 20'h08001, 0, 20'h07FFF, 16'h0101);
		op(4'h8, 1, 0, 20'h00081, 0, 20'h0007F, 16'h0101);
		op(4'h8, 0, 0, 2, 0, 0, 16'h0003);
		op(4'h8, 0, 0, 1, 0, 20'h0FFFF, 16'h0004);
		chk(32'h0000FFFF, {12'h000, result_out}, "result");
		$display("decrement done");
	endtask
	task t_calls;
		apb(`CCBDA_OFF_MEMW, 1'b1, 32'h0000BEEF);
		apb(`CCBDA_OFF_OFFS, 1'b1, 32'h0000FFF0);
		op(4'h9, 0, 0, 20'h01234, 16'h0038, 20'h01236, 16'h0038);
		apb(`CCBDA_OFF_FADDR, 1'b0, 32'h00000000);
		chk(32'h00001234, q, "fetch address");
		apb(`CCBDA_OFF_TGT, 1'b0, 32'h00000000);
		chk(32'h0000BEEF, q, "target");
		op(4'hA, 0, 0, 20'h01000, 16'h0038, 20'h01000, 16'h0038);
		apb(`CCBDA_OFF_FADDR, 1'b0, 32'h00000000);
		chk(32'h00000FF0, q, "fetch address");
		$display("calls done");
	endtask
	task t_refuse;
		apb(8'h28, 1'b0, 32'h00000000);
		chk(32'h00000001, {31'h0, e}, "unmapped error");
		chk(32'h00000000, q, "unmapped data");
		apb(8'h06, 1'b1, 32'h00000001);
		chk(32'h00000001, {31'h0, e}, "unaligned error");
		op(4'hB, 0, 0, 20'h00333, 16'h0005, 20'h00333, 16'h0005);
		apb(`CCBDA_OFF_INFO, 1'b0, 32'h00000000);
		chk(32'h00000001, {31'h0, q[1]}, "bad op flag");
		$display("refusals done");
	endtask
	initial begin
		repeat (5) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		chk(32'h00000000, {16'h0000, status_out}, "status after reset");
		chk(32'h00000000, {12'h000, result_out}, "result after reset");
		chk(32'h00000000, {31'h0, result_we}, "write pulse after reset");
		chk(32'h00000000, prdata, "read data after reset");
		t_clears;
		t_compare;
		t_bcd;
		t_decs;
		t_calls;
		t_refuse;
		end_sim;
	end
endmodule
bind ccbda_alu ccbda_alu_checker #(.AW(AW), .XW(XW)) i_ccbda_alu_checker (
	.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .result_out(result_out),
	.result_we(result_we), .status_out(status_out));
